// [hdl/prc_pkg.sv]
// Operation
// - Regulators one, two, three, five use table A.
// - Regulator four uses its own table B.
// - Converter codes step 0.05V from 0.80V.
// - Converter code zero selects external divider.
// - Startup code n delays n steps; 111 excluded.
// - Mode-force bit selects fixed PWM, else automatic.
// - In standby, enables only arm next startup.
// - When running, enable writes act at once.
// - Register sleep bit counts when pin control off.
// - Register level pick counts when pin control off.
// - Each output has its own discharge bit.
// - After cooling, restart automatically if enable high.
// - Retention set keeps registers through overheat restart.
// - Retention clear reloads defaults before restart.
// - Shutdown status bit shows live shutdown state.
// - Warning status bit shows live warning condition.
// - Thermal status register ignores host writes.
// - Read-only shutdown event flag.
// - Read-only warning event flag.
// - Step is 25us fast, 50us otherwise.
// - Pin control picks level from the pin.
// - Mask bit blocks each thermal event interrupt.
package prc_pkg;

    localparam int ADDR_W = 8;
    localparam int MV_W = 12;
    localparam int RAILS = 6;
    localparam int NREGS = 9;

    // Register offsets.
    localparam logic [7:0] OFS_REG1 = 8'h01;
    localparam logic [7:0] OFS_CONV2 = 8'h07;
    localparam logic [7:0] OFS_SWITCH = 8'h08;
    localparam logic [7:0] OFS_DISCH = 8'h09;
    localparam logic [7:0] OFS_THERM = 8'h0a;
    localparam logic [7:0] OFS_EVENT = 8'h0b;

    // Field positions.
    localparam int LVL_LSB = 0;
    localparam int DLY_LSB = 5;
    localparam int FPWM_BIT = 5;
    localparam int SLEEP_BIT = 6;
    localparam int PICK_BIT = 7;
    localparam int KEEP_BIT = 7;
    localparam int SHUT_BIT = 1;
    localparam int WARN_BIT = 0;
    localparam int CONV_IDX = 5;

    // Writable bits per register, index 0 is offset 0x01.
    localparam logic [NREGS-1:0][7:0] REG_WMASK = {
        8'hbf, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff
    };

    // Power-on values, index 0 is offset 0x01.
    localparam logic [NREGS-1:0][7:0] REG_RESET = {
        8'h3f, 8'h8f, 8'h05, 8'he5, 8'hff, 8'h63, 8'h6c, 8'h75, 8'h7d
    };

    // Startup step timing.
    localparam int CLK_MHZ = 100;
    localparam int STEP_FAST_US = 25;
    localparam int STEP_SLOW_US = 50;
    localparam int STEP_FAST_CYC = STEP_FAST_US * CLK_MHZ;
    localparam int STEP_SLOW_CYC = STEP_SLOW_US * CLK_MHZ;
    localparam logic [2:0] LAST_STEP = 3'h6;
    localparam logic [2:0] NO_START = 3'h7;
    localparam int CNT_W = 16;

    // Converter voltage: base below code one and step, in millivolts.
    localparam logic [MV_W-1:0] CONV_BASE_MV = 12'h2ee;
    localparam logic [MV_W-1:0] CONV_STEP_MV = 12'h032;

    typedef enum logic [1:0] {
        PRC_STANDBY,
        PRC_STARTUP,
        PRC_RUN,
        PRC_SHUTDOWN
    } prc_mode_e;

endpackage

// [hdl/prc_regulator_bank.sv]
`timescale 1ns/1ps
`default_nettype none
module prc_regulator_bank #(
    parameter int STEP_FAST_CYCLES = prc_pkg::STEP_FAST_CYC,
    parameter int STEP_SLOW_CYCLES = prc_pkg::STEP_SLOW_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [prc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output var logic [7:0] reg_rdata,
    output var logic reg_rvalid,
    input wire logic fast_step_select,
    input wire logic pin_driven_low_power,
    input wire logic pin_driven_level_pick,
    input wire logic overheat_shutdown_event_mask,
    input wire logic overheat_warning_event_mask,
    input wire logic enable_pin,
    input wire logic level_select_pin,
    input wire logic overheat_hot,
    input wire logic overheat_cooled,
    input wire logic overheat_warn,
    output var logic [prc_pkg::RAILS-1:0] rail_on,
    output var logic [prc_pkg::RAILS-1:0] rail_discharge,
    output var logic [prc_pkg::RAILS-2:0][prc_pkg::MV_W-1:0] reg_level_mv,
    output var logic [prc_pkg::MV_W-1:0] converter_mv,
    output var logic converter_external_divider,
    output var logic converter_force_pwm,
    output var logic low_power,
    output var logic thermal_event_irq
);
    import prc_pkg::*;

    // All state lives in one packed record.
    // One process builds the next copy.
    // One clocked process stores it.
    // So each bit has a single driver.

    // The record is wide, but the bank is small.
    // Reset and retention stay easy to follow.
    // Retention touches the register file only.

    typedef struct packed {
        logic [NREGS-1:0][7:0] regs;
        prc_mode_e mode;
        logic [2:0] step;
        logic [CNT_W-1:0] tick;
        logic shut_evt;
        logic warn_evt;
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic [7:0] rdata;
        logic rvalid;
        logic [RAILS-1:0] rail_on;
        logic [RAILS-1:0] discharge;
        logic [RAILS-2:0][MV_W-1:0] lvl_mv;
        logic [MV_W-1:0] conv_mv;
        logic ext_div;
        logic fpwm;
        logic sleep;
        logic irq;
    } prc_state_s;

    // Sync bits from 0: enable, level pin,
    // hot, cooled and warning inputs.

    prc_state_s cur_reg;
    prc_state_s cur_next;

    // The level tables are fixed decoders.
    // Codes become millivolts for easy checks.
    // Each table is split into runs of
    // equal steps, as it is not linear.

    // Level table shared by regulators one, two, three and five.
    // Runs of 50mV, 100mV, 50mV steps.
    // The last two codes stand alone.
    function automatic logic [MV_W-1:0] table_a_mv(input logic [4:0] code);
        logic [MV_W-1:0] mv;
        mv = 12'h000;
        if (code < 5'h0f) begin
            mv = 12'h4b0 + 12'(code) * 12'h032;
        end else if (code < 5'h16) begin
            mv = 12'h7d0 + 12'(code - 5'h0f) * 12'h064;
        end else if (code < 5'h1e) begin
            mv = 12'ha5a + 12'(code - 5'h16) * 12'h032;
        end else if (code == 5'h1e) begin
            mv = 12'hc1c;
        end else begin
            mv = 12'hce4;
        end
        return mv;
    endfunction


    // Level table of regulator four.
    // It starts lower, at 0.80V.
    // It has five runs of its own.
    function automatic logic [MV_W-1:0] table_b_mv(input logic [4:0] code);
        logic [MV_W-1:0] mv;
        mv = 12'h000;
        if (code < 5'h03) begin
            mv = 12'h320 + 12'(code) * 12'h032;
        end else if (code < 5'h06) begin
            mv = 12'h3e8 + 12'(code - 5'h03) * 12'h064;
        end else if (code < 5'h14) begin
            mv = 12'h4e2 + 12'(code - 5'h06) * 12'h032;
        end else if (code < 5'h1a) begin
            mv = 12'h7d0 + 12'(code - 5'h14) * 12'h064;
        end else begin
            mv = 12'ha28 + 12'(code - 5'h1a) * 12'h032;
        end
        return mv;
    endfunction


    // Read view of one offset; reserved and unmapped bits read zero.
    // Reads never change state here.
    // The event read is seen in the
    // next-state process instead.
    // Unmapped offsets raise no error.
    function automatic logic [7:0] read_view(input prc_state_s s, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a >= OFS_REG1 && a <= OFS_DISCH) begin
            v = s.regs[4'(a - OFS_REG1)];
        end else if (a == OFS_THERM) begin
            v[SHUT_BIT] = (s.mode == PRC_SHUTDOWN);
            v[WARN_BIT] = s.sync2[4];
        end else if (a == OFS_EVENT) begin
            v[SHUT_BIT] = s.shut_evt;
            v[WARN_BIT] = s.warn_evt;
        end
        return v;
    endfunction

    // Next-state logic of the whole bank.
    always_comb begin
        logic en_s;
        logic lvl_s;
        logic hot_s;
        logic cool_s;
        logic warn_s;
        logic pick;
        logic [4:0] conv_code;
        logic [CNT_W-1:0] step_len;
        logic [RAILS-1:0] armed;
        logic [RAILS-1:0] due;
        logic ev_read;

        // Working values are set first,
        // so no latch can be inferred.
        en_s = cur_reg.sync2[0];
        lvl_s = cur_reg.sync2[1];
        hot_s = cur_reg.sync2[2];
        cool_s = cur_reg.sync2[3];
        warn_s = cur_reg.sync2[4];
        pick = 1'b0;
        conv_code = 5'h00;
        step_len = '0;
        armed = '0;
        due = '0;
        ev_read = 1'b0;
        cur_next = cur_reg;

        // Every field keeps its value
        // unless a branch changes it.
        // Retention then needs no logic.

        // Two flip-flops ahead of every pin; only the second stage is used.
        cur_next.sync1 = {overheat_warn, overheat_cooled, overheat_hot,
                          level_select_pin, enable_pin};
        cur_next.sync2 = cur_reg.sync1;

        // Same-clock inputs are used directly.
        // Only pins and comparators are synced.
        // Nothing reads the first stage.
        // Two cycles are far below one step.

        // Register writes; the thermal registers have no write path.
        if (reg_wr && reg_addr >= OFS_REG1 && reg_addr <= OFS_DISCH) begin
            cur_next.regs[4'(reg_addr - OFS_REG1)] =
                reg_wdata & REG_WMASK[4'(reg_addr - OFS_REG1)];
        end

        // Reserved bits are masked on write,
        // so they always read back zero.
        // Thermal offsets lie outside the
        // range and are dropped silently.
        // A range check keeps decoding small.

        // Reads answer one cycle later with a valid pulse.
        cur_next.rvalid = reg_rd;
        cur_next.rdata = reg_rd ? read_view(cur_reg, reg_addr) : 8'h00;
        ev_read = reg_rd && (reg_addr == OFS_EVENT);

        // Data is zero outside the pulse,
        // so no stale byte is latched.
        // Read with write returns old data.
        // Only the event read has a side effect.

        // Event flags: a live condition always sets, and a read only
        // drops a flag whose cause has gone, so no event is lost.
        cur_next.shut_evt = (cur_reg.shut_evt && !(ev_read && !hot_s))
                            || hot_s;
        cur_next.warn_evt = (cur_reg.warn_evt && !(ev_read && !warn_s))
                            || warn_s;
        cur_next.irq = (cur_reg.shut_evt && !overheat_shutdown_event_mask)
                       || (cur_reg.warn_evt && !overheat_warning_event_mask);

        // The interrupt lags the flags by one.
        // A mask hides a flag, never clears it.
        // A live cause keeps its flag set,
        // because the set term wins.

        // Enable bits and startup slot of each output.
        for (int i = 0; i < RAILS; i++) begin
            armed[i] = cur_reg.regs[OFS_SWITCH - OFS_REG1][i];
            due[i] = armed[i] && (cur_reg.regs[i][DLY_LSB +: 3] == cur_reg.step)
                     && (cur_reg.regs[i][DLY_LSB +: 3] != NO_START);
        end
        step_len = fast_step_select ? CNT_W'(STEP_FAST_CYCLES - 1)
                                    : CNT_W'(STEP_SLOW_CYCLES - 1);

        // The tick runs to step length less one.
        // A new step setting acts at the next
        // compare; the step is not restarted.
        // Code 111 never matches a step, so
        // such outputs come on only in run.

        // Power sequencing.
        // Standby waits for the enable pin.
        // Startup walks seven steps.
        // Run lets enable bits act at once.
        // Shutdown holds all outputs off.
        // Abort and restart begin at step 0.
        unique case (cur_reg.mode)
            PRC_STANDBY: begin
                cur_next.rail_on = '0;
                // Enable writes only arm startup.
                if (en_s) begin
                    cur_next.mode = PRC_STARTUP;
                    cur_next.step = 3'h0;
                    cur_next.tick = '0;
                end
            end
            PRC_STARTUP: begin
                cur_next.rail_on = cur_reg.rail_on | due;
                // Each step only adds outputs.
                if (!en_s) begin
                    cur_next.mode = PRC_STANDBY;
                end else if (cur_reg.tick == step_len) begin
                    cur_next.tick = '0;
                    if (cur_reg.step == LAST_STEP) begin
                        cur_next.mode = PRC_RUN;
                    end else begin
                        cur_next.step = cur_reg.step + 3'h1;
                    end
                end else begin
                    cur_next.tick = cur_reg.tick + CNT_W'(1);
                end
            end
            PRC_RUN: begin
                cur_next.rail_on = armed;
                // Writes show two cycles on.
                if (!en_s) begin
                    cur_next.mode = PRC_STANDBY;
                end
            end
            PRC_SHUTDOWN: begin
                cur_next.rail_on = '0;
                // Restart runs a full startup, so
                // outputs return in order.
                if (cool_s && !hot_s) begin
                    if (!cur_reg.regs[OFS_DISCH - OFS_REG1][KEEP_BIT]) begin
                        cur_next.regs = REG_RESET;
                    end
                    // With retention set the registers are left alone.
                    cur_next.mode = en_s ? PRC_STARTUP : PRC_STANDBY;
                    cur_next.step = 3'h0;
                    cur_next.tick = '0;
                end
            end
        endcase

        // Heat is tested after the case,
        // so it beats every transition.
        // Cooling counts only while not hot,
        // so chatter cannot restart early.
        // Outputs drop at the same edge.

        // Overheat overrides every state.
        if (hot_s) begin
            cur_next.mode = PRC_SHUTDOWN;
            cur_next.rail_on = '0;
        end

        // The choice follows the live pick,
        // so a pin change needs no host.
        // The host keeps code one at or
        // above code two; it is not enforced.
        // Pick and sleep share one pin path.

        // Converter level choice and low-power state.
        pick = pin_driven_level_pick ? lvl_s
                                     : cur_reg.regs[OFS_SWITCH - OFS_REG1][PICK_BIT];
        conv_code = pick ? cur_reg.regs[CONV_IDX][LVL_LSB +: 5]
                         : cur_reg.regs[OFS_CONV2 - OFS_REG1][LVL_LSB +: 5];
        cur_next.sleep = pin_driven_low_power ? !lvl_s
                                              : cur_reg.regs[OFS_SWITCH - OFS_REG1][SLEEP_BIT];
        cur_next.ext_div = (conv_code == 5'h00);
        cur_next.conv_mv = (conv_code == 5'h00) ? 12'h000
                           : CONV_BASE_MV + 12'(conv_code) * CONV_STEP_MV;
        cur_next.fpwm = cur_reg.regs[OFS_CONV2 - OFS_REG1][FPWM_BIT];
        cur_next.discharge = cur_reg.regs[OFS_DISCH - OFS_REG1][RAILS-1:0];

        // Code zero selects the external
        // divider and reports zero volts.
        // Mode and discharge are plain copies.

        // Regulator levels: index 3 is regulator four with its own table.
        for (int i = 0; i < RAILS - 1; i++) begin
            cur_next.lvl_mv[i] = (i == 3) ? table_b_mv(cur_reg.regs[i][LVL_LSB +: 5])
                                          : table_a_mv(cur_reg.regs[i][LVL_LSB +: 5]);
        end
    end


    // Reset loads defaults and standby.
    // Other fields start at zero, so
    // outputs read zero until release.
    // Constants only, so reset is clean.
    // Single state register; reset loads constants only.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_reg <= '0;
            cur_reg.regs <= REG_RESET;
            cur_reg.mode <= PRC_STANDBY;
        end else begin
            cur_reg <= cur_next;
        end
    end


    // Outputs are record fields, so they
    // carry no decoding glitch.
    // All outputs come straight from the state register.
    assign reg_rdata = cur_reg.rdata;
    assign reg_rvalid = cur_reg.rvalid;
    assign rail_on = cur_reg.rail_on;
    assign rail_discharge = cur_reg.discharge;
    assign reg_level_mv = cur_reg.lvl_mv;
    assign converter_mv = cur_reg.conv_mv;
    assign converter_external_divider = cur_reg.ext_div;
    assign converter_force_pwm = cur_reg.fpwm;
    assign low_power = cur_reg.sleep;
    assign thermal_event_irq = cur_reg.irq;

    // Limitation: no write protection;
    // an in-range write always lands.
    // Limitation: event flags are not
    // part of retention.
    // Limitation: steps count core cycles,
    // so set them for the real clock.


endmodule
`default_nettype wire

// [verif/prc_regulator_bank_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module prc_regulator_bank_sva #(
    parameter int STEP_FAST_CYCLES = 4,
    parameter int STEP_SLOW_CYCLES = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [prc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic pin_driven_low_power,
    input wire logic level_select_pin,
    input wire logic enable_pin,
    input wire logic overheat_hot,
    input wire logic overheat_shutdown_event_mask,
    input wire logic overheat_warning_event_mask,
    input wire logic [prc_pkg::RAILS-1:0] rail_on,
    input wire logic [prc_pkg::RAILS-1:0] rail_discharge,
    input wire logic [prc_pkg::MV_W-1:0] converter_mv,
    input wire logic converter_external_divider,
    input wire logic converter_force_pwm,
    input wire logic low_power,
    input wire logic thermal_event_irq
);
    import prc_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // A lone write, so the copy two edges on cannot be overwritten meanwhile.
    sequence s_wr(logic [7:0] a);
        reg_wr && reg_addr == a ##1 !(reg_wr && reg_addr == a);
    endsequence
    // Pins pass two sync flops and then the state register that drives the outputs.
    sequence s_hot;
        overheat_hot [*6];
    endsequence
    sequence s_low;
        !enable_pin [*6];
    endsequence
    a_fpwm_copy: assert property (s_wr(OFS_CONV2) |=>
        converter_force_pwm == $past(reg_wdata[FPWM_BIT], 2)) else $error("pwm bit lost");
    a_disch_copy: assert property (s_wr(OFS_DISCH) |=>
        rail_discharge == $past(reg_wdata[5:0], 2)) else $error("discharge bits lost");
    a_div_flag: assert property ($past(rst_n) |->
        converter_external_divider == (converter_mv == 12'h000)) else $error("divider flag");
    a_conv_step: assert property ($past(rst_n) && converter_mv != 0 |-> converter_mv >= 800
        && converter_mv <= 2300 && converter_mv % 50 == 0) else $error("converter level");
    a_shut_rails: assert property (s_hot |-> rail_on == 0) else $error("rail on when hot");
    a_standby_off: assert property (s_low |-> rail_on == 0) else $error("rail on in standby");
    a_pin_sleep: assert property ((pin_driven_low_power && !level_select_pin) [*5]
        |-> low_power) else $error("no sleep on pin low");
    a_pin_wake: assert property ((pin_driven_low_power && level_select_pin) [*5]
        |-> !low_power) else $error("sleep on pin high");
    a_irq_masked: assert property ((overheat_shutdown_event_mask &&
        overheat_warning_event_mask) [*2] |-> !thermal_event_irq) else $error("masked irq");
endmodule
bind prc_regulator_bank prc_regulator_bank_sva #(
    .STEP_FAST_CYCLES(STEP_FAST_CYCLES),
    .STEP_SLOW_CYCLES(STEP_SLOW_CYCLES)
) sva_u (
    .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .pin_driven_low_power,
    .level_select_pin, .enable_pin, .overheat_hot, .overheat_shutdown_event_mask,
    .overheat_warning_event_mask, .rail_on, .rail_discharge, .converter_mv,
    .converter_external_divider, .converter_force_pwm, .low_power, .thermal_event_irq
);
`default_nettype wire

// [verif/prc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module prc_host_model (
    input wire logic core_clk,
    output var logic [prc_pkg::ADDR_W-1:0] reg_addr,
    output var logic [7:0] reg_wdata,
    output var logic reg_wr,
    output var logic reg_rd
);
    import prc_pkg::*;
    // Quiet bus at time zero.
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // One byte per call; data is inverted after the strobe so stale data never looks valid.
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge core_clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        @(posedge core_clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = ~d;
    endtask
endmodule
`default_nettype wire

// [verif/prc_regulator_bank_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module prc_regulator_bank_tb;
    import prc_pkg::*;
    // Level tables in tens of millivolts, indexed by code.
    int tab_a[32] = '{120, 125, 130, 135, 140, 145, 150, 155, 160, 165, 170, 175, 180, 185,
        190, 200, 210, 220, 230, 240, 250, 260, 265, 270, 275, 280, 285, 290, 295, 300, 310, 330};
    int tab_b[32] = '{80, 85, 90, 100, 110, 120, 125, 130, 135, 140, 145, 150, 155, 160,
        165, 170, 175, 180, 185, 190, 200, 210, 220, 230, 240, 250, 260, 265, 270, 275, 280, 285};
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic pdl = 1'b0, pdp = 1'b0, smask = 1'b0, wmask = 1'b0, en = 1'b0;
    logic lsel = 1'b0, hot = 1'b0, cool = 1'b0, warn = 1'b0, fss = 1'b1;
    wire logic [ADDR_W-1:0] reg_addr;
    wire logic [7:0] reg_wdata;
    wire logic reg_wr, reg_rd;
    logic [7:0] reg_rdata, v;
    logic reg_rvalid, ext_div, fpwm, low_power, irq;
    logic [RAILS-1:0] rail_on, rail_discharge;
    logic [RAILS-2:0][MV_W-1:0] reg_level_mv;
    logic [MV_W-1:0] converter_mv;
    logic [7:0] exp_q[$];
    int n_errors = 0;
    int num_checks = 0;
    prc_host_model host_u (.core_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
    // Short steps keep the startup sequence to a few dozen cycles.
    prc_regulator_bank #(.STEP_FAST_CYCLES(4), .STEP_SLOW_CYCLES(8)) dut_u (
        .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
        .fast_step_select(fss), .pin_driven_low_power(pdp), .pin_driven_level_pick(pdl),
        .overheat_shutdown_event_mask(smask), .overheat_warning_event_mask(wmask),
        .enable_pin(en), .level_select_pin(lsel), .overheat_hot(hot), .overheat_cooled(cool),
        .overheat_warn(warn), .rail_on, .rail_discharge, .reg_level_mv, .converter_mv,
        .converter_external_divider(ext_div), .converter_force_pwm(fpwm), .low_power,
        .thermal_event_irq(irq));
    always #5 core_clk = ~core_clk;
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [11:0] s, input logic [11:0] e);
        num_checks++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    // Inputs move one nanosecond after the edge, so outputs are read settled.
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_u.xfer(a, d, 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.xfer(a, 8'h00, 1'b0);
    endtask
    task automatic wait_rails(input logic [5:0] e, input int lim);
        int i = 0;
        while (rail_on !== e && i < lim) begin
            cyc(1);
            i++;
        end
        check("rail_on", 12'(rail_on), 12'(e));
        if (rail_on !== e) print_verdict();
    endtask
    // Each answer is matched to the oldest outstanding read.
    always @(negedge core_clk) begin
        if (reg_rvalid === 1'b1) begin
            check("rdata", 12'(reg_rdata), exp_q.size() > 0 ? 12'(exp_q.pop_front()) : 12'hfff);
        end
    end
    initial begin
        void'($urandom(32'h8e9f292d));
        cyc(6);
        rst_n = 1'b1;
        for (int i = 0; i < NREGS; i++) rd(8'(i + 1), REG_RESET[i]);
        rd(8'h00, 8'h00);
        rd(8'h0c, 8'h00);
        wr(8'h0a, 8'hff);
        wr(8'h0b, 8'hff);
        rd(8'h0a, 8'h00);
        rd(8'h0b, 8'h00);
        $display("test registers done");
        wr(8'h07, 8'h00);
        for (int c = 0; c < 32; c++) begin
            wr(8'h01, {3'($urandom_range(0, 6)), 5'(c)});
            wr(8'h04, {3'($urandom_range(0, 6)), 5'(c)});
            wr(8'h06, {3'h7, 5'(c)});
            cyc(3);
            check("lvl1", reg_level_mv[0], 12'(tab_a[c] * 10));
            check("lvl4", reg_level_mv[3], 12'(tab_b[c] * 10));
            check("conv", converter_mv, c == 0 ? 12'h000 : 12'(750 + 50 * c));
            check("ext", 12'(ext_div), 12'(c == 0));
        end
        $display("test decode done");
        wr(8'h07, 8'h22);
        wr(8'h06, 8'he5);
        wr(8'h08, 8'h0f);
        cyc(3);
        check("conv", converter_mv, 12'd850);
        check("pwm", 12'(fpwm), 12'h001);
        pdl = 1'b1;
        lsel = 1'b1;
        cyc(5);
        check("conv", converter_mv, 12'd1000);
        lsel = 1'b0;
        cyc(5);
        check("conv", converter_mv, 12'd850);
        pdl = 1'b0;
        wr(8'h08, 8'hcf);
        wr(8'h07, 8'h02);
        cyc(3);
        check("conv", converter_mv, 12'd1000);
        check("pwm", 12'(fpwm), 12'h000);
        check("sleep", 12'(low_power), 12'h001);
        pdp = 1'b1;
        lsel = 1'b1;
        cyc(5);
        check("sleep", 12'(low_power), 12'h000);
        lsel = 1'b0;
        wr(8'h08, 8'h8f);
        cyc(5);
        check("sleep", 12'(low_power), 12'h001);
        pdp = 1'b0;
        cyc(3);
        check("sleep", 12'(low_power), 12'h000);
        repeat (4) begin
            v = 8'($urandom) & 8'h3f;
            wr(8'h09, v);
            cyc(3);
            check("disch", 12'(rail_discharge), 12'(v));
            rd(8'h09, v);
        end
        $display("test controls done");
        wr(8'h01, 8'h1d);
        wr(8'h02, 8'hd5);
        wr(8'h08, 8'h83);
        en = 1'b1;
        cyc(10);
        check("rail_on", 12'(rail_on), 12'h001);
        wait_rails(6'h03, 200);
        wr(8'h08, 8'h85);
        wait_rails(6'h05, 20);
        en = 1'b0;
        wait_rails(6'h00, 20);
        wr(8'h08, 8'h8f);
        cyc(10);
        check("rail_on", 12'(rail_on), 12'h000);
        fss = 1'b0;
        wr(8'h08, 8'h83);
        en = 1'b1;
        cyc(40);
        check("rail_on", 12'(rail_on), 12'h001);
        wait_rails(6'h03, 200);
        en = 1'b0;
        fss = 1'b1;
        wait_rails(6'h00, 20);
        wr(8'h08, 8'h8f);
        $display("test startup done");
        warn = 1'b1;
        cyc(5);
        rd(8'h0a, 8'h01);
        check("irq", 12'(irq), 12'h001);
        wmask = 1'b1;
        cyc(3);
        check("irq", 12'(irq), 12'h000);
        warn = 1'b0;
        cyc(5);
        rd(8'h0a, 8'h00);
        rd(8'h0b, 8'h01);
        rd(8'h0b, 8'h00);
        wr(8'h09, 8'hbf);
        wr(8'h01, 8'h1e);
        en = 1'b1;
        wait_rails(6'h0f, 300);
        hot = 1'b1;
        cyc(6);
        check("rail_on", 12'(rail_on), 12'h000);
        check("irq", 12'(irq), 12'h001);
        rd(8'h0a, 8'h02);
        rd(8'h0b, 8'h02);
        hot = 1'b0;
        cool = 1'b1;
        wait_rails(6'h0f, 300);
        cool = 1'b0;
        rd(8'h01, 8'h1e);
        rd(8'h0b, 8'h02);
        wr(8'h09, 8'h3f);
        smask = 1'b1;
        hot = 1'b1;
        cyc(6);
        check("irq", 12'(irq), 12'h000);
        hot = 1'b0;
        cool = 1'b1;
        wait_rails(6'h0f, 300);
        rd(8'h01, 8'h7d);
        rd(8'h07, 8'h05);
        $display("test thermal done");
        cyc(5);
        check("pending", 12'(exp_q.size()), 12'h000);
        print_verdict();
    end
endmodule
`default_nettype wire
